// File: hw/sdcp_pkg.sv
// Purpose: Shared constants for the command pipeline and refresh block.
// Assumes: One system clock; memory commands are {ras_n, cas_n, we_n}.
// Notes:   Cycle counts are stored as count minus one for the wait timer.
package sdcp_pkg;
    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_REFI = 4'h4;
    localparam logic [3:0] OFF_STAT = 4'h8;
    localparam int CTRL_USER_REF = 0;
    localparam int CTRL_DLL_GATE = 1;
    localparam logic [1:0]  CTRL_RESET   = 2'h0;
    localparam logic [15:0] REFI_MAX     = 16'hfffe;
    localparam logic [15:0] REFI_LEAD    = 16'h0010;
    localparam int STAT_BUSY = 0;
    localparam int STAT_UPEND = 1;
    localparam int STAT_CNT_LSB = 16;

    // =====================================================================
    // Memory commands and timing
    // =====================================================================
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [3:0] TRCD_WAIT = 4'h1;
    localparam logic [3:0] TWR_WAIT  = 4'h1;
    localparam logic [3:0] TRP_WAIT  = 4'h1;
    localparam logic [3:0] TRFC_WAIT = 4'h6;
    localparam logic [3:0] WAIT_ZERO = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ACT_WAIT, ST_WR_REC, ST_PRE_WAIT, ST_REF_WAIT
    } sdcp_state_t;
endpackage

// File: hw/sdcp_pipe_stage.sv
// Purpose: One register stage of the command and address path.
// Assumes: Clock edge choice is fixed at elaboration.
// Notes:   Reset loads the idle pattern so the memory sees no command.
`timescale 1ns/1ns
`default_nettype none
module sdcp_pipe_stage #(
    parameter int               WIDTH    = 8,
    parameter bit               NEG_EDGE = 1'b0,
    parameter logic [WIDTH-1:0] RST_VAL  = '1
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // Data
    input  wire logic [WIDTH-1:0] d_in,
    output var  logic [WIDTH-1:0] q_out
);
    // =====================================================================
    // Stage register
    // =====================================================================
    generate
        if (NEG_EDGE)
        begin : g_neg
            // Falling edge gives the memory half a cycle of setup margin.
            always_ff @(negedge sys_clk or negedge reset_n)
            begin
                if (!reset_n) q_out <= RST_VAL;
                else          q_out <= d_in;
            end
        end
        else
        begin : g_pos
            // Rising edge stage adds one whole cycle of latency.
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n) q_out <= RST_VAL;
                else          q_out <= d_in;
            end
        end
    endgenerate
endmodule // sdcp_pipe_stage
`default_nettype wire

// File: hw/sdcp_cmd_pipe.sv
// Purpose: Command scheduler, refresh options and output pipeline.
// Assumes: Local inputs synchronous to sys_clk; one bank opened per access.
// Notes:   Pipeline options are structural parameters; refresh mode and
//          DLL gating are software controlled.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sdcp_cmd_pipe #(
    parameter int          ADDR_W        = 13,
    parameter bit          ADDR_CMD_PIPE = 1'b1,
    parameter bit          EXTRA_PIPE    = 1'b0,
    parameter bit          NEG_EDGE      = 1'b0,
    parameter logic [15:0] REFI_DEFAULT  = sdcp_pkg::REFI_MAX
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // Register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output var  logic [31:0]       reg_rdata,
    // Local request side
    input  wire logic              local_req,
    input  wire logic              local_write,
    input  wire logic [ADDR_W-1:0] local_row,
    input  wire logic [ADDR_W-1:0] local_col,
    output var  logic              local_ready,
    input  wire logic              local_refresh_req,
    output var  logic              local_refresh_ack,
    // Memory side
    output logic [2:0]             mem_cmd,
    output logic [ADDR_W-1:0]      mem_addr,
    output var  logic              dll_update_en
);
    // =====================================================================
    // Pipeline shape
    // =====================================================================
    localparam bit EXTRA_EN = ADDR_CMD_PIPE && EXTRA_PIPE;
    localparam int NSTAGE = 1 + int'(ADDR_CMD_PIPE) + int'(EXTRA_EN);
    localparam int PW = 3 + ADDR_W;
    localparam logic [PW-1:0] PIPE_IDLE =
        {sdcp_pkg::CMD_NOP, {ADDR_W{1'b0}}};

    sdcp_pkg::sdcp_state_t state_reg, state_next;
    logic [3:0]        wait_reg, wait_next;
    logic [1:0]        ctrl_reg;
    logic [15:0]       refi_reg, refi_cnt_reg;
    logic              user_pend_reg, is_write_reg;
    logic [ADDR_W-1:0] col_reg;
    logic [2:0]        cmd_next;
    logic [ADDR_W-1:0] addr_next;
    logic [31:0]       rdata_next;

    wire user_mode = ctrl_reg[sdcp_pkg::CTRL_USER_REF];
    wire dll_gate  = ctrl_reg[sdcp_pkg::CTRL_DLL_GATE];
    wire wait_done = (wait_reg == sdcp_pkg::WAIT_ZERO);
    wire ref_issue = (cmd_next == sdcp_pkg::CMD_REF);
    wire accept    = local_ready && local_req;
    wire [15:0] refi_lim = (refi_reg > sdcp_pkg::REFI_LEAD) ?
        refi_reg - sdcp_pkg::REFI_LEAD : 16'h0000;
    wire auto_due  = !user_mode && (refi_cnt_reg >= refi_lim);
    wire ref_due   = user_mode ? user_pend_reg : auto_due;
    wire ready_next = (state_next == sdcp_pkg::ST_IDLE) && !ref_due;

    // =====================================================================
    // Register port
    // =====================================================================
    // Writes above the limit are clamped so the interval never exceeds it.
    wire [15:0] refi_wr = (reg_wdata[15:0] > sdcp_pkg::REFI_MAX) ?
        sdcp_pkg::REFI_MAX : reg_wdata[15:0];
    wire wr_ctrl = reg_wr && (reg_addr == sdcp_pkg::OFF_CTRL);
    wire wr_refi = reg_wr && (reg_addr == sdcp_pkg::OFF_REFI);

    // Read mux; unmapped offsets and idle cycles return zero.
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (reg_rd)
        begin
            unique case (reg_addr)
                sdcp_pkg::OFF_CTRL: rdata_next[1:0]  = ctrl_reg;
                sdcp_pkg::OFF_REFI: rdata_next[15:0] = refi_reg;
                sdcp_pkg::OFF_STAT:
                begin
                    rdata_next[sdcp_pkg::STAT_BUSY]  = !local_ready;
                    rdata_next[sdcp_pkg::STAT_UPEND] = user_pend_reg;
                    rdata_next[sdcp_pkg::STAT_CNT_LSB +: 16] = refi_cnt_reg;
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg  <= sdcp_pkg::CTRL_RESET;
            refi_reg  <= REFI_DEFAULT;
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            if (wr_ctrl) ctrl_reg <= reg_wdata[1:0];
            if (wr_refi) refi_reg <= refi_wr;
            reg_rdata <= rdata_next;
        end
    end

    // =====================================================================
    // Command scheduler
    // =====================================================================
    // Refresh only starts from idle, where every bank is already closed.
    always_comb
    begin
        state_next = state_reg;
        wait_next  = wait_done ? wait_reg : wait_reg - 4'h1;
        cmd_next   = sdcp_pkg::CMD_NOP;
        addr_next  = '0;
        unique case (state_reg)
            sdcp_pkg::ST_IDLE:
                if (accept)
                begin
                    cmd_next   = sdcp_pkg::CMD_ACT;
                    addr_next  = local_row;
                    wait_next  = sdcp_pkg::TRCD_WAIT;
                    state_next = sdcp_pkg::ST_ACT_WAIT;
                end
                else if (ref_due)
                begin
                    cmd_next   = sdcp_pkg::CMD_REF;
                    wait_next  = sdcp_pkg::TRFC_WAIT;
                    state_next = sdcp_pkg::ST_REF_WAIT;
                end
            sdcp_pkg::ST_ACT_WAIT:
                if (wait_done)
                begin
                    cmd_next   = is_write_reg ? sdcp_pkg::CMD_WR
                                              : sdcp_pkg::CMD_RD;
                    addr_next  = col_reg;
                    wait_next  = sdcp_pkg::TWR_WAIT;
                    state_next = sdcp_pkg::ST_WR_REC;
                end
            sdcp_pkg::ST_WR_REC:
                if (wait_done)
                begin
                    cmd_next   = sdcp_pkg::CMD_PRE;
                    wait_next  = sdcp_pkg::TRP_WAIT;
                    state_next = sdcp_pkg::ST_PRE_WAIT;
                end
            sdcp_pkg::ST_PRE_WAIT,
            sdcp_pkg::ST_REF_WAIT:
                if (wait_done) state_next = sdcp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg    <= sdcp_pkg::ST_IDLE;
            wait_reg     <= sdcp_pkg::WAIT_ZERO;
            local_ready  <= 1'b0;
            is_write_reg <= 1'b0;
            col_reg      <= '0;
        end
        else
        begin
            state_reg   <= state_next;
            wait_reg    <= wait_next;
            local_ready <= ready_next;
            if (accept)
            begin
                is_write_reg <= local_write;
                col_reg      <= local_col;
            end
        end
    end

    // =====================================================================
    // Refresh bookkeeping and DLL gate
    // =====================================================================
    // A request landing in the issue cycle is kept: set beats clear.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            user_pend_reg     <= 1'b0;
            refi_cnt_reg      <= 16'h0000;
            local_refresh_ack <= 1'b0;
            dll_update_en     <= 1'b1;
        end
        else
        begin
            if (local_refresh_req)
                user_pend_reg <= 1'b1;
            else if (ref_issue)
                user_pend_reg <= 1'b0;
            if (ref_issue)
                refi_cnt_reg <= 16'h0000;
            else if (refi_cnt_reg != 16'hffff)
                refi_cnt_reg <= refi_cnt_reg + 16'h0001;
            local_refresh_ack <= ref_issue;
            // Gating holds the DLL still everywhere outside refresh issue and refresh wait to cut jitter.
            dll_update_en <= !dll_gate || ref_issue ||
                             (state_next == sdcp_pkg::ST_REF_WAIT);
        end
    end

    // =====================================================================
    // Output pipeline
    // =====================================================================
    logic [PW-1:0] pipe_w [0:NSTAGE];
    assign pipe_w[0] = {cmd_next, addr_next};
    genvar gi;
    generate
        for (gi = 0; gi < NSTAGE; gi++)
        begin : g_stage
            // The last stage is the output register; the first of three
            // is the extra stage and shares its edge choice.
            localparam bit NEG = NEG_EDGE && ((gi == NSTAGE - 1) ||
                                 (EXTRA_EN && gi == 0));
            sdcp_pipe_stage #(
                .WIDTH    (PW),
                .NEG_EDGE (NEG),
                .RST_VAL  (PIPE_IDLE)
            ) u_stage (
                .sys_clk (sys_clk),
                .reset_n (reset_n),
                .d_in    (pipe_w[gi]),
                .q_out   (pipe_w[gi+1])
            );
        end
    endgenerate
    assign mem_cmd  = pipe_w[NSTAGE][PW-1 -: 3];
    assign mem_addr = pipe_w[NSTAGE][ADDR_W-1:0];

    // =====================================================================
    // Checks
    // =====================================================================
    localparam int RC_LAT = NSTAGE;
    sequence s_ref_cmd;
        cmd_next == sdcp_pkg::CMD_REF;
    endsequence
    sequence s_req_taken;
        local_ready && local_req;
    endsequence

    a_pipe_latency: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!NEG_EDGE && $past(reset_n, RC_LAT)) |->
        mem_cmd == $past(cmd_next, RC_LAT))
        else $error("Command latency differs from stage count.");
    a_stage_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!ADDR_CMD_PIPE && !NEG_EDGE && $past(reset_n)) |->
        mem_cmd == $past(cmd_next))
        else $error("Extra stage present without command pipeline.");
    a_user_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (s_ref_cmd and user_mode) |-> user_pend_reg)
        else $error("Refresh issued in user mode without a request.");
    a_auto_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!user_mode && refi_cnt_reg == refi_lim && refi_lim != 16'h0000
         && state_reg == sdcp_pkg::ST_IDLE && !accept) |-> s_ref_cmd)
        else $error("Automatic refresh not issued when due.");
    a_dll_blocked: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (dll_gate && state_next == sdcp_pkg::ST_ACT_WAIT) |=> !dll_update_en)
        else $error("DLL update allowed outside refresh.");
    a_refi_limit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_refi |=> refi_reg <= sdcp_pkg::REFI_MAX)
        else $error("Refresh interval above limit.");
    a_ref_closed: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_ref_cmd |-> state_reg == sdcp_pkg::ST_IDLE ##1
        (state_reg == sdcp_pkg::ST_REF_WAIT && local_refresh_ack) ##1
        (state_reg == sdcp_pkg::ST_REF_WAIT && !local_refresh_ack)[*6]
        ##1 state_reg == sdcp_pkg::ST_IDLE)
        else $error("Refresh issued with an access open.");
    a_req_sequence: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_req_taken |-> cmd_next == sdcp_pkg::CMD_ACT ##2
        (cmd_next == sdcp_pkg::CMD_RD || cmd_next == sdcp_pkg::CMD_WR) ##2
        cmd_next == sdcp_pkg::CMD_PRE)
        else $error("Access command order broken.");
endmodule // sdcp_cmd_pipe
`default_nettype wire

// File: verification/sdcp_mem_model.sv
// Purpose: Behavioural memory that logs the commands sent to it.
// Assumes: Each command stands one cycle; it is sampled 1 ns after a change.
// Notes:   Flags any access or refresh that breaks the open-row order.
`timescale 1ns/1ns
`default_nettype none
module sdcp_mem_model #(
    parameter int ADDR_W = 13
) (
    // Memory pins
    input  wire logic [2:0]        mem_cmd,
    input  wire logic [ADDR_W-1:0] mem_addr,
    // Observations
    output var  logic [ADDR_W-1:0] act_row,
    output var  logic [ADDR_W-1:0] rw_col,
    output var  logic [2:0]        rw_cmd,
    output var  longint            act_t,
    output var  longint            rw_t,
    output var  longint            pre_t,
    output var  longint            ref_t,
    output var  int                ref_cnt,
    output var  logic              proto_err
);
    logic row_open;

    // =====================================================================
    // Command log
    // =====================================================================
    // The late look lets an address from the same stage settle first.
    always @(mem_cmd)
    begin
        #1;
        case (mem_cmd)
            sdcp_pkg::CMD_ACT:
            begin
                proto_err = proto_err | row_open;
                row_open  = 1'b1;
                act_row   = mem_addr;
                act_t     = $time - 1;
            end
            sdcp_pkg::CMD_RD, sdcp_pkg::CMD_WR:
            begin
                proto_err = proto_err | ~row_open;
                rw_col    = mem_addr;
                rw_cmd    = mem_cmd;
                rw_t      = $time - 1;
            end
            sdcp_pkg::CMD_PRE:
            begin
                row_open = 1'b0;
                pre_t    = $time - 1;
            end
            sdcp_pkg::CMD_REF:
            begin
                // A refresh into an open bank would lose the row.
                proto_err = proto_err | row_open;
                ref_cnt   = ref_cnt + 1;
                ref_t     = $time - 1;
            end
            default:
            begin
            end
        endcase
    end

    // Start with every bank closed and nothing logged.
    initial
    begin
        row_open  = 1'b0;
        proto_err = 1'b0;
        ref_cnt   = 0;
    end
endmodule // sdcp_mem_model
`default_nettype wire

// File: verification/tb_sdcp_cmd_pipe.sv
// Purpose: Self-checking bench for the command pipeline and refresh block.
// Assumes: Three builds share inputs: both stages, falling edge, extra only.
// Notes:   Latencies are measured in ns from the accepting edge.
`timescale 1ns/1ns
`default_nettype none
module tb_sdcp_cmd_pipe;
    localparam logic [2:0] P_PIPE  = 3'h3;
    localparam logic [2:0] P_EXTRA = 3'h5;
    localparam logic [2:0] P_NEG   = 3'h2;
    // Each rising stage after the first costs a cycle; a falling
    // output stage shows the command half a cycle after its source edge.
    localparam longint     EXP_ACT [3] = '{100, 25, 0};
    typedef struct packed {
        logic        wr;
        logic [12:0] row;
        logic [12:0] col;
        logic [2:0]  cmd;
    } sdcp_case_t;
    localparam sdcp_case_t CASES [4] = '{
        '{1'h1, 13'h1fff, 13'h0000, sdcp_pkg::CMD_WR},
        '{1'h0, 13'h0000, 13'h1fff, sdcp_pkg::CMD_RD},
        '{1'h0, 13'h0aaa, 13'h1555, sdcp_pkg::CMD_RD},
        '{1'h1, 13'h1555, 13'h0aaa, sdcp_pkg::CMD_WR}};

    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        local_req = 1'b0;
    logic        local_write = 1'b0;
    logic [12:0] local_row = 13'h0;
    logic [12:0] local_col = 13'h0;
    logic        local_refresh_req = 1'b0;
    logic [31:0] reg_rdata [3];
    logic        local_ready [3];
    logic        ref_ack [3];
    logic [2:0]  mem_cmd [3];
    logic [12:0] mem_addr [3];
    logic        dll_en [3];
    logic [12:0] act_row [3];
    logic [12:0] rw_col [3];
    logic [2:0]  rw_cmd [3];
    longint      act_t [3];
    longint      rw_t [3];
    longint      pre_t [3];
    longint      ref_t [3];
    int          ref_cnt [3];
    logic        proto_err [3];
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;
    logic [31:0] rd;
    longint      t;
    bit          seen;
    int          c;

    // =====================================================================
    // Designs and memory models
    // =====================================================================
    for (genvar g = 0; g < 3; g++)
    begin : g_dut
        sdcp_cmd_pipe #(.ADDR_W(13), .ADDR_CMD_PIPE(P_PIPE[g]),
            .EXTRA_PIPE(P_EXTRA[g]), .NEG_EDGE(P_NEG[g]),
            .REFI_DEFAULT(sdcp_pkg::REFI_MAX)) u_sdcp_cmd_pipe (
            .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
            .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
            .reg_rdata(reg_rdata[g]), .local_req(local_req),
            .local_write(local_write), .local_row(local_row),
            .local_col(local_col), .local_ready(local_ready[g]),
            .local_refresh_req(local_refresh_req),
            .local_refresh_ack(ref_ack[g]), .mem_cmd(mem_cmd[g]),
            .mem_addr(mem_addr[g]), .dll_update_en(dll_en[g]));
        sdcp_mem_model #(.ADDR_W(13)) u_sdcp_mem_model (
            .mem_cmd(mem_cmd[g]), .mem_addr(mem_addr[g]),
            .act_row(act_row[g]), .rw_col(rw_col[g]), .rw_cmd(rw_cmd[g]),
            .act_t(act_t[g]), .rw_t(rw_t[g]), .pre_t(pre_t[g]),
            .ref_t(ref_t[g]), .ref_cnt(ref_cnt[g]),
            .proto_err(proto_err[g]));
    end

    // =====================================================================
    // Clock, timeout and tasks
    // =====================================================================
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    // The run needs about 380 cycles; the ceiling leaves a wide margin.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_time(input string what, input longint exp,
                            input longint got);
        n_checks++;
        if (got != exp)
        begin
            miscompares++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Strobes drop one edge later and a quiet edge follows each write.
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata[0];
    endtask

    // One access; a refresh request may be raised at the accepting edge.
    task automatic access(input sdcp_case_t k, input bit with_ref);
        for (int n = 0; n < 40 && local_ready[0] !== 1'b1; n++)
            @(posedge sys_clk);
        local_req <= 1'b1;
        local_write <= k.wr;
        local_row <= k.row;
        local_col <= k.col;
        @(posedge sys_clk);
        t = $time;
        local_req <= 1'b0;
        local_refresh_req <= with_ref;
        @(posedge sys_clk);
        local_refresh_req <= 1'b0;
        repeat (16) @(posedge sys_clk);
        for (int i = 0; i < 3; i++)
        begin
            chk_val("row", {19'h0, k.row}, {19'h0, act_row[i]});
            chk_val("col", {19'h0, k.col}, {19'h0, rw_col[i]});
            chk_val("cmd", {29'h0, k.cmd}, {29'h0, rw_cmd[i]});
            chk_time("act delay", EXP_ACT[i], act_t[i] - t);
            chk_time("rw gap", 100, rw_t[i] - act_t[i]);
            chk_time("pre gap", 100, pre_t[i] - rw_t[i]);
        end
    endtask

    task automatic wait_ref(input int lim, output bit hit);
        int c0;
        c0 = ref_cnt[0];
        hit = 1'b0;
        for (int n = 0; n < lim && !hit; n++)
        begin
            @(posedge sys_clk);
            hit = ref_cnt[0] != c0;
        end
    endtask

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial
    begin
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 3; i++)
            chk_val("reset cmd", 32'h7, {29'h0, mem_cmd[i]});
        chk_val("reset ready", 32'h0, {31'h0, local_ready[0]});
        chk_val("reset dll", 32'h1, {31'h0, dll_en[0]});
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reg_read(sdcp_pkg::OFF_REFI, rd);
        chk_val("refi reset", 32'h0000fffe, rd);
        reg_write(sdcp_pkg::OFF_REFI, 32'h0000ffff);
        reg_read(sdcp_pkg::OFF_REFI, rd);
        chk_val("refi clamp", 32'h0000fffe, rd);
        reg_write(4'hc, 32'hffffffff);
        reg_read(4'hc, rd);
        chk_val("unmapped", 32'h0, rd);
        reg_read(sdcp_pkg::OFF_CTRL, rd);
        chk_val("ctrl reset", 32'h0, rd);
        // Idle with nothing pending: busy and pending flags both low.
        reg_read(sdcp_pkg::OFF_STAT, rd);
        chk_val("stat idle", 32'h0, {30'h0, rd[1:0]});
        foreach (CASES[k])
            access(CASES[k], 1'b0);
        // Automatic refresh at a short programmed interval.
        reg_write(sdcp_pkg::OFF_REFI, 32'h00000028);
        wait_ref(60, seen);
        chk_val("auto refresh", 32'h1, {31'h0, seen});
        t = ref_t[0];
        wait_ref(60, seen);
        chk_val("refresh spacing", 32'h1, {31'h0, ref_t[0] - t <= 2000});
        // User refresh with DLL gating.
        reg_write(sdcp_pkg::OFF_CTRL, 32'h3);
        repeat (20) @(posedge sys_clk);
        c = ref_cnt[0];
        chk_val("dll idle", 32'h0, {31'h0, dll_en[0]});
        repeat (200) @(posedge sys_clk);
        chk_val("no auto ref", c, ref_cnt[0]);
        local_refresh_req <= 1'b1;
        @(posedge sys_clk);
        local_refresh_req <= 1'b0;
        for (int n = 0; n < 20 && ref_ack[0] !== 1'b1; n++)
            @(posedge sys_clk);
        chk_val("ack", 32'h1, {31'h0, ref_ack[0]});
        chk_val("dll refresh", 32'h1, {31'h0, dll_en[0]});
        repeat (12) @(posedge sys_clk);
        chk_val("user ref", c + 1, ref_cnt[0]);
        chk_val("dll after", 32'h0, {31'h0, dll_en[0]});
        // Refresh asked for while an access is running.
        access(CASES[0], 1'b1);
        chk_val("ref merged", c + 2, ref_cnt[0]);
        chk_val("ref after pre", 32'h1, {31'h0, ref_t[0] > pre_t[0]});
        for (int i = 0; i < 3; i++)
            chk_val("order", 32'h0, {31'h0, proto_err[i]});
        end_of_test();
    end
endmodule // tb_sdcp_cmd_pipe
`default_nettype wire
